// ### pkg/ptdc_pkg.sv
// Constants and types shared by the paired thickness/difference logic
package ptdc_pkg;
   localparam int DW = 32;
   localparam int AW = 8;

   typedef enum logic [2:0] {
      MODE_ALONE = 3'h0,
      MODE_SEC   = 3'h1,
      MODE_THICK = 3'h2,
      MODE_DIFF  = 3'h3,
      MODE_AUTO  = 3'h4
   } ptdc_mode_t;

   // Register byte addresses
   localparam logic [AW-1:0] A_MODE    = 8'h00;
   localparam logic [AW-1:0] A_CMD     = 8'h04;
   localparam logic [AW-1:0] A_REF     = 8'h08;
   localparam logic [AW-1:0] A_SPACING = 8'h0C;
   localparam logic [AW-1:0] A_OFFSET  = 8'h10;
   localparam logic [AW-1:0] A_SP1_D   = 8'h14;
   localparam logic [AW-1:0] A_SP2_D   = 8'h18;
   localparam logic [AW-1:0] A_SP1_P   = 8'h1C;
   localparam logic [AW-1:0] A_SP2_P   = 8'h20;
   localparam logic [AW-1:0] A_TOL     = 8'h24;
   localparam logic [AW-1:0] A_SLOPE   = 8'h28;
   localparam logic [AW-1:0] A_STATUS  = 8'h2C;
   localparam logic [AW-1:0] A_VALUE   = 8'h30;
   localparam logic [AW-1:0] A_ANALOG  = 8'h34;

   // Field positions
   localparam int CMD_REF_BIT   = 0;
   localparam int ST_PEND_BIT   = 3;
   localparam int ST_DONE_BIT   = 4;
   localparam int ST_ADPT_BIT   = 5;

   // Reset values, micrometres
   localparam logic [DW-1:0] SPACING_RST = 32'h0014_2440;
   localparam logic [DW-1:0] OFFSET_RST  = 32'h0000_0000;
   localparam logic [DW-1:0] REF_RST     = 32'h0000_0000;
   localparam logic [DW-1:0] TOL_RST     = 32'h0009_27C0;
   localparam logic [DW-1:0] SP_RST      = 32'h0000_0000;

   // Analog codes: mid-scale is 12 mA / 5 V
   localparam logic [15:0] ANA_MID   = 16'h8000;
   localparam int          ANA_SHIFT = 15;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_NS  = 1_000_000;
   localparam int TICK_CYC      = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam int HOLD_TIME_MS  = 10_000;
   localparam int FLASH_TIME_MS = 200;
endpackage

// ### pkg/ptdc_ana_if.sv
// Carrier between the main logic and the analog tolerance scaler
`timescale 1ns/10ps
interface ptdc_ana_if;
   logic signed [31:0] value;
   logic signed [31:0] ref_thick;
   logic        [31:0] range;
   logic               slope_neg;
   logic        [15:0] code;
   modport src (output value, output ref_thick, output range, output slope_neg, input code);
   modport scl (input value, input ref_thick, input range, input slope_neg, output code);
endinterface

// ### rtl/ptdc_ana_scale.sv
// Analog tolerance-mode scaler with saturation
`timescale 1ns/10ps
module ptdc_ana_scale
   import ptdc_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   ptdc_ana_if.scl   ana
);
   logic signed [33:0] dev;
   logic signed [32:0] half;
   logic signed [48:0] quo;
   logic signed [48:0] sum;
   logic        [15:0] next_code;

   always_comb begin
      dev = 34'(ana.value) - 34'(ana.ref_thick);
      if (ana.slope_neg) begin
         dev = -dev;
      end
      // Zero range would divide by zero; treat it as the narrowest window
      half = (ana.range[31:1] == 31'h0) ? 33'sh1 : $signed({2'h0, ana.range[31:1]});
      quo  = $signed({dev, 15'h0000}) / 49'(half);
      sum  = quo + 49'sh0_8000;
      if (sum[48]) begin
         next_code = 16'h0000;
      end else if (|sum[47:16]) begin
         next_code = 16'hFFFF;
      end else begin
         next_code = sum[15:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ana.code <= ANA_MID;
      end else begin
         ana.code <= next_code;
      end
   end

   mid_ref_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (ana.value == ana.ref_thick) |=> (ana.code == ANA_MID))
      else $error("reference value not at mid-scale");
   sat_high_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (!ana.slope_neg && ana.value > ana.ref_thick + $signed(ana.range))
      |=> (ana.code == 16'hFFFF))
      else $error("analog code did not saturate high");
   slope_dir_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (ana.slope_neg && ana.value > ana.ref_thick + $signed({1'b0, ana.range[31:1]}))
      |=> (ana.code == 16'h0000))
      else $error("negative slope did not fall");
endmodule

// ### rtl/ptdc_teach_keys.sv
// Teach-key hold timer and indicator flashing
`timescale 1ns/10ps
module ptdc_teach_keys #(
   parameter int HOLD_MS  = 10_000,
   parameter int FLASH_MS = 200
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_tick,
   input  wire logic i_key,
   output logic      o_ref_req,
   output logic      o_led
);
   typedef enum logic [3:0] {
      KS_IDLE  = 4'b0001,
      KS_HOLD  = 4'b0010,
      KS_ARMED = 4'b0100,
      KS_CONF  = 4'b1000
   } ptdc_key_t;

   ptdc_key_t   state;
   logic [15:0] ms_cnt;
   logic [15:0] fl_cnt;
   logic [1:0]  halves;
   logic        blink;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state     <= KS_IDLE;
         ms_cnt    <= 16'h0000;
         o_ref_req <= 1'b0;
         halves    <= 2'h0;
      end else begin
         o_ref_req <= 1'b0;
         case (state)
            KS_IDLE: begin
               ms_cnt <= 16'h0000;
               if (i_key) begin
                  state <= KS_HOLD;
               end
            end
            KS_HOLD: begin
               if (!i_key) begin
                  state <= KS_IDLE;
               end else if (i_tick) begin
                  ms_cnt <= ms_cnt + 16'h0001;
                  if (ms_cnt == 16'(HOLD_MS - 1)) begin
                     state <= KS_ARMED;
                  end
               end
            end
            KS_ARMED: begin
               halves <= 2'h0;
               if (!i_key) begin
                  o_ref_req <= 1'b1;
                  state     <= KS_CONF;
               end
            end
            KS_CONF: begin
               if (i_tick && fl_cnt == 16'(FLASH_MS - 1)) begin
                  halves <= halves + 2'h1;
                  if (halves == 2'h3) begin
                     state <= KS_IDLE;
                  end
               end
            end
            default: state <= KS_IDLE;
         endcase
      end
   end

   // Flash phase timer shared by the busy and confirm patterns
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fl_cnt <= 16'h0000;
         blink  <= 1'b0;
      end else if (state == KS_ARMED && !i_key) begin
         fl_cnt <= 16'h0000;
         blink  <= 1'b0;
      end else if (i_tick) begin
         if (fl_cnt == 16'(FLASH_MS - 1)) begin
            fl_cnt <= 16'h0000;
            blink  <= ~blink;
         end else begin
            fl_cnt <= fl_cnt + 16'h0001;
         end
      end
   end

   // Confirm shows on, off, on, off: two brief flashes
   assign o_led = (state == KS_ARMED) ? blink : (state == KS_CONF) ? ~halves[0] : 1'b0;

   req_after_arm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_ref_req) |-> $past(state == KS_ARMED) && $past(!i_key))
      else $error("teach request without completed hold");
endmodule

// ### rtl/ptdc_top.sv
// Paired thickness/difference calculation with referencing and outputs
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module ptdc_top
   import ptdc_pkg::*;
#(
   parameter int TICK_CYCLES = ptdc_pkg::TICK_CYC,
   parameter int HOLD_MS     = ptdc_pkg::HOLD_TIME_MS,
   parameter int FLASH_MS    = ptdc_pkg::FLASH_TIME_MS
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_rst_n,
   input  wire logic [ptdc_pkg::AW-1:0]    i_addr,
   input  wire logic [ptdc_pkg::DW-1:0]    i_wdata,
   input  wire logic                       i_wr,
   input  wire logic                       i_rd,
   output logic      [ptdc_pkg::DW-1:0]    o_rdata,
   input  wire logic                       i_teach_key,
   input  wire logic                       i_enter_key,
   input  wire logic                       i_adapter_seen,
   input  wire logic                       i_adapter_main,
   input  wire logic                       i_menu_ref,
   input  wire logic                       i_radio_ref,
   input  wire logic                       i_iolink_ref,
   input  wire logic signed [31:0]         i_main_dist,
   input  wire logic signed [31:0]         i_sec_dist,
   input  wire logic                       i_meas_valid,
   output logic signed [31:0]              o_out_value,
   output logic      [15:0]                o_analog_code,
   output logic                            o_switch_channel_one,
   output logic                            o_switch_channel_two,
   output logic                            o_led_one,
   output logic                            o_led_two,
   output ptdc_pkg::ptdc_mode_t            o_eff_mode
);
   import ptdc_pkg::*;

   ptdc_ana_if ana ();

   // Pin synchronisers; first stage feeds only the second
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic       teach_k;
   logic       enter_k;
   logic       adpt_seen;
   logic       adpt_main;
   logic       enter_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_s1 <= 4'h0;
         pin_s2 <= 4'h0;
      end else begin
         pin_s1 <= {i_adapter_main, i_adapter_seen, i_enter_key, i_teach_key};
         pin_s2 <= pin_s1;
      end
   end

   assign teach_k   = pin_s2[0];
   assign enter_k   = pin_s2[1];
   assign adpt_seen = pin_s2[2];
   assign adpt_main = pin_s2[3];

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         enter_q <= 1'b0;
      end else begin
         enter_q <= enter_k;
      end
   end

   // Millisecond enable for the key timing
   logic [31:0] div_cnt;
   logic        tick;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_cnt <= 32'h0000_0000;
         tick    <= 1'b0;
      end else if (div_cnt == 32'(TICK_CYCLES - 1)) begin
         div_cnt <= 32'h0000_0000;
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 32'h0000_0001;
         tick    <= 1'b0;
      end
   end

   // Configuration registers
   ptdc_mode_t         cfg_mode;
   logic signed [31:0] ref_thick;
   logic signed [31:0] spacing;
   logic signed [31:0] align_ofs;
   logic signed [31:0] sp1_dist;
   logic signed [31:0] sp2_dist;
   logic signed [31:0] sp1_pair;
   logic signed [31:0] sp2_pair;
   logic        [31:0] tol_range;
   logic               slope_neg;
   logic               sw_ref;

   function automatic logic hit(input logic [AW-1:0] a);
      return i_wr && (i_addr == a);
   endfunction

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_mode <= MODE_AUTO;
      end else if (hit(A_MODE) && i_wdata[2:0] <= MODE_AUTO) begin
         cfg_mode <= ptdc_mode_t'(i_wdata[2:0]);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ref_thick <= REF_RST;
         sp1_dist  <= SP_RST;
         sp2_dist  <= SP_RST;
         sp1_pair  <= SP_RST;
         sp2_pair  <= SP_RST;
         tol_range <= TOL_RST;
         slope_neg <= 1'b0;
      end else if (i_wr) begin
         if (i_addr == A_REF) begin
            ref_thick <= i_wdata;
         end else if (i_addr == A_SP1_D) begin
            sp1_dist <= i_wdata;
         end else if (i_addr == A_SP2_D) begin
            sp2_dist <= i_wdata;
         end else if (i_addr == A_SP1_P) begin
            sp1_pair <= i_wdata;
         end else if (i_addr == A_SP2_P) begin
            sp2_pair <= i_wdata;
         end else if (i_addr == A_TOL) begin
            tol_range <= i_wdata;
         end else if (i_addr == A_SLOPE) begin
            slope_neg <= i_wdata[0];
         end
      end
   end

   assign sw_ref = hit(A_CMD) && i_wdata[CMD_REF_BIT];

   // Effective mode; the adapter only steers automatic mode
   ptdc_mode_t eff_mode;
   logic       paired;
   logic       thick;

   always_comb begin
      if (cfg_mode != MODE_AUTO) begin
         eff_mode = cfg_mode;
      end else if (!adpt_seen) begin
         eff_mode = MODE_ALONE;
      end else if (adpt_main) begin
         eff_mode = MODE_THICK;
      end else begin
         eff_mode = MODE_SEC;
      end
   end

   assign paired     = (eff_mode == MODE_THICK) || (eff_mode == MODE_DIFF);
   assign thick      = (eff_mode == MODE_THICK);
   assign o_eff_mode = eff_mode;

   // Referencing: every source merges into one request
   logic key_req;
   logic key_led;
   logic any_req;
   logic ref_pend;
   logic ref_done;
   logic referenced;
   logic ref_take;

   ptdc_teach_keys #(
      .HOLD_MS  (HOLD_MS),
      .FLASH_MS (FLASH_MS)
   ) u_keys (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_tick    (tick),
      .i_key     (teach_k),
      .o_ref_req (key_req),
      .o_led     (key_led)
   );

   assign any_req  = key_req || (enter_k && !enter_q) || i_menu_ref
                     || i_radio_ref || i_iolink_ref || sw_ref;
   assign ref_take = ref_pend && i_meas_valid && paired;

   // A request landing on the completing cycle stays pending
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ref_pend <= 1'b0;
      end else if (any_req && paired) begin
         ref_pend <= 1'b1;
      end else if (ref_take || !paired) begin
         ref_pend <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ref_done   <= 1'b0;
         referenced <= 1'b0;
      end else begin
         ref_done <= ref_take;
         if (ref_take) begin
            referenced <= 1'b1;
         end
      end
   end

   // Calibration wins over a software write in the same cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         spacing   <= SPACING_RST;
         align_ofs <= OFFSET_RST;
      end else if (ref_take) begin
         if (thick) begin
            spacing <= ref_thick + i_main_dist + i_sec_dist;
         end else begin
            align_ofs <= i_main_dist - i_sec_dist - ref_thick;
         end
      end else if (hit(A_SPACING)) begin
         spacing <= i_wdata;
      end else if (hit(A_OFFSET)) begin
         align_ofs <= i_wdata;
      end
   end

   // Measurement result
   logic signed [31:0] calc;

   always_comb begin
      if (thick) begin
         calc = spacing - i_main_dist - i_sec_dist;
      end else begin
         calc = i_main_dist - i_sec_dist - align_ofs;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_out_value <= 32'sh0000_0000;
      end else if (i_meas_valid) begin
         o_out_value <= paired ? calc : i_main_dist;
      end
   end

   // Switching channels; timing and logic stay with the general channel settings
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_switch_channel_one <= 1'b0;
         o_switch_channel_two <= 1'b0;
      end else begin
         o_switch_channel_one <= o_out_value >= (paired ? sp1_pair : sp1_dist);
         o_switch_channel_two <= o_out_value >= (paired ? sp2_pair : sp2_dist);
      end
   end

   // Analog tolerance mode
   assign ana.value     = o_out_value;
   assign ana.ref_thick = ref_thick;
   assign ana.range     = tol_range;
   assign ana.slope_neg = slope_neg;

   ptdc_ana_scale u_ana (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .ana     (ana)
   );

   // Stand-alone analog characteristics live elsewhere; hold mid-scale here
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_analog_code <= ANA_MID;
      end else begin
         o_analog_code <= paired ? ana.code : ANA_MID;
      end
   end

   // Both LEDs mirror the teach pattern
   assign o_led_one = key_led;
   assign o_led_two = key_led;

   // Register read, data valid only in the cycle after the strobe
   logic [31:0] rd_mux;
   logic [31:0] status;

   assign status = {26'h0, adpt_seen, referenced, ref_pend, eff_mode};

   always_comb begin
      if (i_addr == A_MODE) begin
         rd_mux = {29'h0, cfg_mode};
      end else if (i_addr == A_REF) begin
         rd_mux = ref_thick;
      end else if (i_addr == A_SPACING) begin
         rd_mux = spacing;
      end else if (i_addr == A_OFFSET) begin
         rd_mux = align_ofs;
      end else if (i_addr == A_SP1_D) begin
         rd_mux = sp1_dist;
      end else if (i_addr == A_SP2_D) begin
         rd_mux = sp2_dist;
      end else if (i_addr == A_SP1_P) begin
         rd_mux = sp1_pair;
      end else if (i_addr == A_SP2_P) begin
         rd_mux = sp2_pair;
      end else if (i_addr == A_TOL) begin
         rd_mux = tol_range;
      end else if (i_addr == A_SLOPE) begin
         rd_mux = {31'h0, slope_neg};
      end else if (i_addr == A_STATUS) begin
         rd_mux = status;
      end else if (i_addr == A_VALUE) begin
         rd_mux = o_out_value;
      end else if (i_addr == A_ANALOG) begin
         rd_mux = {16'h0, o_analog_code};
      end else begin
         rd_mux = 32'h0000_0000;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 32'h0000_0000;
      end else begin
         o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // Checks
   mode_legal_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cfg_mode <= MODE_AUTO)
      else $error("configured mode out of range");

   auto_main_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (cfg_mode == MODE_AUTO && adpt_seen && adpt_main) |-> (eff_mode == MODE_THICK))
      else $error("automatic preset not thickness");

   thick_cal_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (ref_take && thick)
      |=> (spacing == $past(ref_thick) + $past(i_main_dist) + $past(i_sec_dist)))
      else $error("spacing not calibrated");

   diff_cal_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (ref_take && eff_mode == MODE_DIFF)
      |=> (align_ofs == $past(i_main_dist) - $past(i_sec_dist) - $past(ref_thick)))
      else $error("offset not calibrated");

   out_calc_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_meas_valid && paired) |=> (o_out_value == $past(calc)))
      else $error("paired output not calculated value");

   req_pend_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (any_req && paired) |=> ref_pend)
      else $error("referencing request lost");

   switch_pair_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (paired && o_out_value >= sp1_pair && $stable(paired)) |=> o_switch_channel_one)
      else $error("channel one ignored paired point");

   analog_ref_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (paired && o_out_value == ref_thick)
      |-> ##2 (o_analog_code == ANA_MID))
      else $error("analog not mid-scale at reference value");

   rd_only_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !$past(i_rd) |-> (o_rdata == 32'h0000_0000))
      else $error("read data outside answer cycle");
endmodule

// ### test/ptdc_sec_model.sv
// Secondary sensor model: hands its distance over with a one-cycle valid pulse
`timescale 1ns/10ps
module ptdc_sec_model (
   input  wire logic        i_clk,
   input  wire logic        i_go,
   input  wire logic [31:0] i_dist,
   output logic             o_valid,
   output logic [31:0]      o_dist
);
   initial o_valid = 1'h0;
   initial o_dist = 32'h0;
   // Data are only held with valid; afterwards flip to the inverse and back every cycle so stale use shows up
   always @(posedge i_clk) begin
      o_valid <= i_go;
      o_dist  <= i_go ? i_dist : ~o_dist;
   end
endmodule

// ### test/ptdc_top_bench.sv
// Self-checking bench for the paired thickness/difference block
`timescale 1ns/10ps
module ptdc_top_bench;
   import ptdc_pkg::*;
   logic        i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, go = 0, vld, lv, lv2, lvp, sw2;
   logic        i_teach_key = 0, i_enter_key = 0, i_adapter_seen = 0, i_adapter_main = 0;
   logic [2:0]  rq = '0;
   logic [7:0]  i_addr = '0;
   logic [31:0] i_wdata = '0, sec_d, main_d = '0, sec_in = '0, o_rdata, rnd = 32'h5A8B;
   logic signed [31:0] o_out_value;
   logic [15:0] o_analog_code;
   logic        o_switch_channel_one;
   ptdc_mode_t  o_eff_mode, md;
   int          err_count = 0, cmp_count = 0, cyc = 0, sp, off = 0, rf = 0, tol, slp, pend = 0;
   int          n, m, s;

   ptdc_sec_model sec (.i_clk, .i_go(go), .i_dist(sec_in), .o_valid(vld), .o_dist(sec_d));
   ptdc_top #(.TICK_CYCLES(10), .HOLD_MS(5), .FLASH_MS(2)) uut (
      .i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_teach_key,
      .i_enter_key, .i_adapter_seen, .i_adapter_main, .i_menu_ref(rq[0]),
      .i_radio_ref(rq[1]), .i_iolink_ref(rq[2]), .i_main_dist(main_d), .i_sec_dist(sec_d),
      .i_meas_valid(vld), .o_out_value, .o_analog_code, .o_switch_channel_one,
      .o_switch_channel_two(sw2), .o_led_one(lv), .o_led_two(lv2), .o_eff_mode);

   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc > 20000) begin
         err_count++;
         test_done;
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'h1;
      @(posedge i_clk);
      i_wr <= 1'h0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      i_addr <= a;
      i_rd <= 1'h1;
      @(posedge i_clk);
      i_rd <= 1'h0;
      #1;
      chk(nm, e, o_rdata);
   endtask
   task automatic pick;
      rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      m = 200000 + int'(rnd[15:0]);
      s = 300000 + int'(rnd[31:16]);
   endtask
   // Sources: 0 command register, 1 menu, 2 radio, 3 fieldbus, 4 enter key
   task automatic req(input int k);
      if (k == 0) wr(A_CMD, 32'h1);
      else if (k < 4) begin
         rq[k-1] <= 1'h1;
         @(posedge i_clk);
         rq <= '0;
      end else begin
         i_enter_key <= 1'h1;
         repeat (4) @(posedge i_clk);
         i_enter_key <= 1'h0;
      end
      pend = 1;
      repeat (4) @(posedge i_clk);
      #1;
   endtask
   task automatic meas(input int mm, input int ss);
      int v;
      longint d, c;
      main_d <= mm;
      sec_in <= ss;
      go <= 1'h1;
      @(posedge i_clk);
      go <= 1'h0;
      v = md == MODE_THICK ? sp - mm - ss : md == MODE_DIFF ? mm - ss - off : mm;
      if (pend && md == MODE_THICK) sp = rf + mm + ss;
      if (pend && md == MODE_DIFF) off = mm - ss - rf;
      pend = 0;
      d = slp ? rf - v : v - rf;
      c = 32768 + d * 32768 / (tol < 2 ? 1 : tol / 2);
      c = md == MODE_ALONE ? 32768 : c < 0 ? 0 : c > 65535 ? 65535 : c;
      repeat (4) @(posedge i_clk);
      #1;
      chk("value", v, o_out_value);
      chk("analog", 32'(c), 32'(o_analog_code));
      chk("switch", md != MODE_ALONE && v >= rf, 32'(o_switch_channel_one));
      chk("switch two", md != MODE_ALONE && v > rf, 32'(sw2));
   endtask

   initial begin
      md = MODE_ALONE;
      sp = SPACING_RST;
      tol = TOL_RST;
      slp = 0;
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'h1;
      repeat (3) @(posedge i_clk);
      #1;
      rd(A_MODE, 32'h4, "mode");
      rd(A_SPACING, SPACING_RST, "spacing");
      rd(A_OFFSET, OFFSET_RST, "offset");
      rd(A_REF, REF_RST, "reference");
      rd(A_TOL, TOL_RST, "tolerance");
      rd(8'hFC, 32'h0, "unmapped");
      chk("auto alone", MODE_ALONE, 32'(o_eff_mode));
      wr(A_SP1_D, 32'h7FFF_FFFF);
      wr(A_SP2_D, 32'h7FFF_FFFF);
      pick;
      meas(m, s);
      i_adapter_seen <= 1'h1;
      repeat (3) @(posedge i_clk);
      #1;
      chk("auto secondary", MODE_SEC, 32'(o_eff_mode));
      i_adapter_main <= 1'h1;
      repeat (3) @(posedge i_clk);
      #1;
      chk("auto main", MODE_THICK, 32'(o_eff_mode));
      $display("test modes done");
      md = MODE_THICK;
      rf = 5000;
      wr(A_REF, rf);
      wr(A_SP1_P, rf);
      wr(A_SP2_P, rf + 1);
      for (int k = 0; k < 5; k++) begin
         pick;
         req(k);
         meas(m, s);
         meas(m, s);
      end
      $display("test referencing done");
      tol = 1000;
      wr(A_TOL, tol);
      for (slp = 0; slp < 2; slp++) begin
         wr(A_SLOPE, slp);
         for (int j = 0; j < 8; j++) begin
            pick;
            // Spread of +-1024 around the reference covers both linear and saturated codes
            meas(sp - rf - 300000 - int'(rnd[10:0]) + 1024, 300000);
         end
      end
      slp = 1;
      $display("test analog done");
      wr(A_MODE, 32'h3);
      wr(A_MODE, 32'h5);
      rd(A_MODE, 32'h3, "mode kept");
      md = MODE_DIFF;
      chk("diff mode", MODE_DIFF, 32'(o_eff_mode));
      pick;
      req(0);
      meas(m, s);
      meas(m, s);
      meas(s, m);
      rd(A_OFFSET, off, "offset");
      rd(A_SPACING, sp, "spacing");
      $display("test difference done");
      wr(A_MODE, 32'h2);
      md = MODE_THICK;
      i_teach_key <= 1'h1;
      repeat (75) @(posedge i_clk);
      i_teach_key <= 1'h0;
      n = 0;
      // Release needs two synchroniser edges and one state edge to reach the confirm pattern
      repeat (3) @(posedge i_clk);
      #1;
      chk("confirm on", 1, 32'(lv));
      lvp = lv;
      repeat (150) begin
         @(posedge i_clk);
         #1;
         n += int'(lvp && !lv);
         lvp = lv;
         chk("led two", 32'(lv), 32'(lv2));
      end
      chk("flashes", 2, n);
      pend = 1;
      pick;
      meas(m, s);
      meas(m, s);
      $display("test teach key done");
      test_done;
   end
endmodule
